/* acs_consts.svh */
// constants for the clock output and sysref control block
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
`define ACS_OFF_CTRL 12'h000
`define ACS_OFF_AUX 12'h004
`define ACS_OFF_CMOS 12'h008
`define ACS_OFF_SYSREF 12'h00c
`define ACS_OFF_POS 12'h010
`define ACS_OFF_STATUS 12'h014
`define ACS_CTRL_RST 32'h0000_0001
`define ACS_AUX_RST 32'h0000_0000
`define ACS_CMOS_RST 32'h0000_0000
`define ACS_SYSREF_RST 32'h0000_0000
`define ACS_AUX_EN_BIT 0
`define ACS_AUX_MODE_LSB 1
`define ACS_AUX_DIV_LSB 4
`define ACS_CMOS_C_LSB 0
`define ACS_CMOS_D_LSB 2
`define ACS_CMOS_OVR_BIT 4
`define ACS_CMOS_OR_BIT 5
`define ACS_SEL_CHANGE_GAP 4'h3
`define ACS_SYSREF_TAPS 24
`endif

/* acs_pkg.sv */
// types for the clock output and sysref control block
package acs_pkg;
   typedef enum logic [1:0] {
      ACS_SEL_OFF = 2'h0,
      ACS_SEL_REF = 2'h1,
      ACS_SEL_DIV2 = 2'h2,
      ACS_SEL_DIV4 = 2'h3
   } acs_sel_t;
   typedef enum logic [2:0] {
      ACS_AUX_TIME = 3'h3,
      ACS_AUX_SERDES = 3'h1
   } acs_aux_mode_t;
   typedef enum logic [1:0] {
      ACS_GS_RUN = 2'b00,
      ACS_GS_GATE = 2'b01,
      ACS_GS_LOAD = 2'b11
   } acs_gate_st_t;
endpackage

/* acs_glitch_gate.sv */
// safe reselection of a clock output: gate low, wait, then load
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_glitch_gate #(
   parameter int W = 3
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // requested and applied setting
   input wire logic [W-1:0] want,
   output logic [W-1:0] applied,
   output logic gate_open
);
   import acs_pkg::*;
   acs_gate_st_t st_q, st_d;
   logic [W-1:0] app_q, app_d;
   logic [3:0] cnt_q, cnt_d;
   always_comb begin
      st_d = st_q;
      app_d = app_q;
      cnt_d = cnt_q;
      case (st_q)
         ACS_GS_RUN: begin
            if (want != app_q) begin
               st_d = ACS_GS_GATE;
               cnt_d = `ACS_SEL_CHANGE_GAP;
            end
         end
         ACS_GS_GATE: begin
            if (cnt_q == 4'h0) begin
               st_d = ACS_GS_LOAD;
               app_d = want;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         ACS_GS_LOAD: st_d = ACS_GS_RUN;
         default: st_d = ACS_GS_RUN;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ACS_GS_RUN;
         app_q <= '0;
         cnt_q <= 4'h0;
      end else begin
         st_q <= st_d;
         app_q <= app_d;
         cnt_q <= cnt_d;
      end
   end
   assign applied = app_q;
   assign gate_open = (st_q == ACS_GS_RUN);
endmodule // acs_glitch_gate

/* acs_div_out.sv */
// divided-clock generator: ref, ref/2, ref/4 or programmable n, from enable pulses
`timescale 1ns/100ps
module acs_div_out #(
   parameter int DW = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // reference edge pulse and divisor in half periods
   input wire logic tick,
   input wire logic en,
   input wire logic [DW-1:0] half,
   output logic clk_out
);
   logic [DW-1:0] cnt_q, cnt_d;
   logic out_q, out_d;
   always_comb begin
      cnt_d = cnt_q;
      out_d = out_q;
      if (!en) begin
         cnt_d = '0;
         out_d = 1'b0;
      end else if (tick) begin
         if (cnt_q + 1'b1 >= half) begin
            cnt_d = '0;
            out_d = ~out_q;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         out_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end
   assign clk_out = out_q;
endmodule // acs_div_out

/* acs_clock_ctrl.sv */
// clock output selection, enables and sysref capture with an apb register file
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`include "acs_consts.svh"
module acs_clock_ctrl #(
   parameter bit QUAD_PART = 1'b1,
   parameter int TAPS = `ACS_SYSREF_TAPS
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // device pins
   input wire logic pll_enable_pin,
   input wire logic power_down_pin,
   input wire logic ref_input_select,
   input wire logic [1:0] clock_cfg_pins,
   // reference, serdes, time mark and sysref samples
   input wire logic diff_ref_in,
   input wire logic single_ended_ref_in,
   input wire logic serdes_clk_in,
   input wire logic time_mark_in,
   input wire logic sysref_in,
   input wire logic [TAPS-1:0] sysref_taps_in,
   input wire logic overrange_c_in,
   input wire logic overrange_d_in,
   // clock outputs
   output logic ref_repeat_out,
   output logic aux_lvds_out,
   output logic cmos_out_c,
   output logic cmos_out_d,
   // captured sysref
   output logic sysref_capture
);
   import acs_pkg::*;
   // synchronisers for pins and asynchronous inputs
   localparam int NS = 9;
   logic [NS-1:0] s1_q, s2_q;
   logic [NS-1:0] async_in;
   assign async_in = {pll_enable_pin, power_down_pin, ref_input_select, clock_cfg_pins,
      diff_ref_in, single_ended_ref_in, serdes_clk_in, time_mark_in};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
      end
   end
   logic pll_en, pwr_dn, ref_sel, ref_d, ref_se, serdes, tmark;
   logic [1:0] cfg;
   assign {pll_en, pwr_dn, ref_sel, cfg, ref_d, ref_se, serdes, tmark} = s2_q;
   // sysref window samples are also asynchronous
   logic [TAPS-1:0] t1_q, t2_q, pos_q, pos_d;
   logic sr1_q, sr2_q;
   // registers
   logic [31:0] ctrl_q, ctrl_d, aux_q, aux_d, cmos_q, cmos_d, srf_q, srf_d;
   logic wr, rd;
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign pready = 1'b1;
   always_comb begin
      ctrl_d = ctrl_q;
      aux_d = aux_q;
      cmos_d = cmos_q;
      srf_d = srf_q;
      if (wr) begin
         case (paddr)
            `ACS_OFF_CTRL: ctrl_d = {31'h0, pwdata[0]};
            `ACS_OFF_AUX: aux_d = {20'h0, pwdata[11:0]};
            `ACS_OFF_CMOS: cmos_d = {26'h0, pwdata[5:0]};
            `ACS_OFF_SYSREF: srf_d = {27'h0, pwdata[4:0]};
            default: ctrl_d = ctrl_q;
         endcase
      end
   end
   logic unmapped;
   assign unmapped = !(paddr inside {`ACS_OFF_CTRL, `ACS_OFF_AUX, `ACS_OFF_CMOS,
      `ACS_OFF_SYSREF, `ACS_OFF_POS, `ACS_OFF_STATUS});
   assign pslverr = psel & penable & unmapped;
   logic [31:0] rdata_d, rdata_q;
   logic [3:0] status;
   always_comb begin
      rdata_d = rdata_q;
      if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `ACS_OFF_CTRL: rdata_d = ctrl_q;
            `ACS_OFF_AUX: rdata_d = aux_q;
            `ACS_OFF_CMOS: rdata_d = cmos_q;
            `ACS_OFF_SYSREF: rdata_d = srf_q;
            `ACS_OFF_POS: rdata_d = 32'(pos_q);
            `ACS_OFF_STATUS: rdata_d = {28'h0, status};
            default: rdata_d = 32'h0;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `ACS_CTRL_RST;
         aux_q <= `ACS_AUX_RST;
         cmos_q <= `ACS_CMOS_RST;
         srf_q <= `ACS_SYSREF_RST;
         rdata_q <= 32'h0;
      end else begin
         ctrl_q <= ctrl_d;
         aux_q <= aux_d;
         cmos_q <= cmos_d;
         srf_q <= srf_d;
         rdata_q <= rdata_d;
      end
   end
   assign prdata = rd ? rdata_q : 32'h0;
   // reference repeat
   logic ref_sig, rep_en;
   assign ref_sig = ref_sel ? ref_se : ref_d;
   assign rep_en = pll_en & ~pwr_dn & ctrl_q[0];
   // reference edge pulse drives the c and d output dividers
   logic ref_prev_q, ref_tick;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ref_prev_q <= 1'b0;
      else ref_prev_q <= ref_sig;
   end
   assign ref_tick = ref_sig ^ ref_prev_q;
   // cmos selection
   acs_sel_t c_sel, d_sel;
   logic ovr;
   assign ovr = cmos_q[`ACS_CMOS_OVR_BIT];
   always_comb begin
      if (ovr) c_sel = acs_sel_t'(cmos_q[`ACS_CMOS_C_LSB +: 2]);
      else c_sel = acs_sel_t'(cfg);
      if (ovr) d_sel = acs_sel_t'(cmos_q[`ACS_CMOS_D_LSB +: 2]);
      else d_sel = (cfg != 2'b00) ? ACS_SEL_REF : ACS_SEL_OFF;
      if (c_sel == ACS_SEL_OFF) d_sel = ACS_SEL_OFF;
   end
   // safe changes on each cmos output
   logic [2:0] c_app, d_app;
   logic c_open, d_open;
   acs_glitch_gate #(.W(3)) u_gate_c (.pclk(pclk), .presetn(presetn),
      .want({~pwr_dn, c_sel}), .applied(c_app), .gate_open(c_open));
   acs_glitch_gate #(.W(3)) u_gate_d (.pclk(pclk), .presetn(presetn),
      .want({~pwr_dn, d_sel}), .applied(d_app), .gate_open(d_open));
   function automatic logic [7:0] half_of(input logic [1:0] s);
      case (s)
         ACS_SEL_DIV2: half_of = 8'h2;
         ACS_SEL_DIV4: half_of = 8'h4;
         default: half_of = 8'h1;
      endcase
   endfunction
   logic c_div, d_div;
   acs_div_out #(.DW(8)) u_div_c (.pclk(pclk), .presetn(presetn), .tick(ref_tick),
      .en(c_open & c_app[2] & (c_app[1:0] > 2'h1)), .half(half_of(c_app[1:0])),
      .clk_out(c_div));
   acs_div_out #(.DW(8)) u_div_d (.pclk(pclk), .presetn(presetn), .tick(ref_tick),
      .en(d_open & d_app[2] & (d_app[1:0] > 2'h1)), .half(half_of(d_app[1:0])),
      .clk_out(d_div));
   // aux output: serdes divided or time mark
   logic aux_en;
   logic [2:0] aux_mode;
   logic [7:0] aux_div;
   logic [2:0] aux_app;
   logic aux_open, aux_serdes, sd_prev_q, aux_clk;
   assign aux_en = aux_q[`ACS_AUX_EN_BIT];
   assign aux_mode = aux_q[`ACS_AUX_MODE_LSB +: 3];
   assign aux_div = aux_q[`ACS_AUX_DIV_LSB +: 8];
   acs_glitch_gate #(.W(3)) u_gate_aux (.pclk(pclk), .presetn(presetn),
      .want(aux_en ? aux_mode : 3'h0), .applied(aux_app), .gate_open(aux_open));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) sd_prev_q <= 1'b0;
      else sd_prev_q <= serdes;
   end
   assign aux_serdes = aux_open & (aux_app == ACS_AUX_SERDES);
   acs_div_out #(.DW(8)) u_div_aux (.pclk(pclk), .presetn(presetn),
      .tick(serdes ^ sd_prev_q), .en(aux_serdes & (aux_div != 8'h0)),
      .half(aux_div), .clk_out(aux_clk));
   // output registers
   logic rep_q, aux_o_q, c_q, d_q;
   logic rep_d, aux_o_d, c_d, d_d;
   always_comb begin
      rep_d = rep_en & ref_sig;
      aux_o_d = 1'b0;
      if (aux_open & (aux_app == ACS_AUX_TIME)) aux_o_d = tmark;
      else if (aux_serdes) aux_o_d = aux_clk;
      c_d = 1'b0;
      if (c_open & c_app[2]) begin
         case (c_app[1:0])
            ACS_SEL_REF: c_d = ref_sig;
            ACS_SEL_DIV2, ACS_SEL_DIV4: c_d = c_div;
            default: c_d = QUAD_PART & cmos_q[`ACS_CMOS_OR_BIT] & overrange_c_in;
         endcase
      end
      d_d = 1'b0;
      if (d_open & d_app[2]) begin
         case (d_app[1:0])
            ACS_SEL_REF: d_d = ref_sig;
            ACS_SEL_DIV2, ACS_SEL_DIV4: d_d = d_div;
            default: d_d = QUAD_PART & cmos_q[`ACS_CMOS_OR_BIT] & overrange_d_in;
         endcase
      end
   end
   // sysref capture on a fixed edge after selectable tap delay
   logic [15:0] tap_hist_q, tap_hist_d;
   logic cap_q, cap_d;
   always_comb begin
      tap_hist_d = {tap_hist_q[14:0], sr2_q};
      pos_d = pos_q;
      // tap that differs from the tap below it is flagged as marginal
      pos_d = t2_q ^ {t2_q[TAPS-2:0], t2_q[TAPS-1]};
      pos_d[0] = 1'b1;
      pos_d[TAPS-1] = 1'b1;
      cap_d = tap_hist_q[srf_q[3:0]];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rep_q <= 1'b0;
         aux_o_q <= 1'b0;
         c_q <= 1'b0;
         d_q <= 1'b0;
         t1_q <= '0;
         t2_q <= '0;
         pos_q <= '0;
         sr1_q <= 1'b0;
         sr2_q <= 1'b0;
         tap_hist_q <= 16'h0;
         cap_q <= 1'b0;
      end else begin
         rep_q <= rep_d;
         aux_o_q <= aux_o_d;
         c_q <= c_d;
         d_q <= d_d;
         t1_q <= sysref_taps_in;
         t2_q <= t1_q;
         pos_q <= pos_d;
         sr1_q <= sysref_in;
         sr2_q <= sr1_q;
         tap_hist_q <= tap_hist_d;
         cap_q <= cap_d;
      end
   end
   assign status = {aux_open, d_open, c_open, rep_en};
   assign ref_repeat_out = rep_q;
   assign aux_lvds_out = aux_o_q;
   assign cmos_out_c = c_q;
   assign cmos_out_d = d_q;
   assign sysref_capture = cap_q;
endmodule // acs_clock_ctrl

/* acs_asserts.sv */
// port checker for the clock control block
`timescale 1ns/100ps
module acs_asserts (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and outputs
   input wire logic pll_enable_pin,
   input wire logic power_down_pin,
   input wire logic sysref_in,
   input wire logic ref_repeat_out,
   input wire logic aux_lvds_out,
   input wire logic cmos_out_c,
   input wire logic cmos_out_d,
   input wire logic sysref_capture
);
   logic acc;
   logic aux_q;
   logic ctrl_q;
   logic [4:0] pwrdn_q;
   logic [4:0] pll_q;
   logic [4:0] sr_q;
   assign acc = psel && penable;
   // saturating run lengths and write history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwrdn_q <= 5'h0;
         pll_q <= 5'h0;
         sr_q <= 5'h1f;
         aux_q <= 1'b0;
         ctrl_q <= 1'b0;
      end else begin
         pwrdn_q <= !power_down_pin ? 5'h0 : pwrdn_q + {4'h0, pwrdn_q != 5'h1f};
         pll_q <= pll_enable_pin ? 5'h0 : pll_q + {4'h0, pll_q != 5'h1f};
         sr_q <= sysref_in ? 5'h0 : sr_q + {4'h0, sr_q != 5'h1f};
         if (acc && pwrite && paddr == 12'h004 && pwdata[0]) aux_q <= 1'b1;
         if (acc && pwrite && paddr == 12'h000) ctrl_q <= 1'b1;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   repeat_pwrdn_a: assert property (pwrdn_q >= 5'd20 |-> !ref_repeat_out)
      else $error("repeat output live in power-down");
   repeat_pll_a: assert property (pll_q >= 5'd20 |-> !ref_repeat_out)
      else $error("repeat output live without pll enable");
   cmos_pwrdn_a: assert property (pwrdn_q >= 5'd20 |-> !cmos_out_c && !cmos_out_d)
      else $error("cmos output live in power-down");
   aux_start_a: assert property (!aux_q |-> !aux_lvds_out)
      else $error("aux output live before enable");
   sysref_cause_a: assert property ($rose(sysref_capture) |-> sr_q < 5'd28)
      else $error("capture without recent sysref");
   pos_ends_a: assert property (acc && !pwrite && paddr == 12'h010 |-> prdata[0] && prdata[23])
      else $error("position end bits not set");
   ctrl_reset_a: assert property (acc && !pwrite && paddr == 12'h000 && !ctrl_q |-> prdata[0])
      else $error("repeat enable not set after reset");
   unmapped_err_a: assert property (acc && paddr > 12'h014 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   pready_high_a: assert property (acc |-> pready)
      else $error("access phase not completed");
   cover property (pwrdn_q == 5'd20);
   cover property ($rose(sysref_capture));
   cover property (aux_q && $rose(aux_lvds_out));
endmodule // acs_asserts
bind acs_clock_ctrl acs_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pll_enable_pin, .power_down_pin, .sysref_in,
   .ref_repeat_out, .aux_lvds_out, .cmos_out_c, .cmos_out_d, .sysref_capture);

/* acs_far_model.sv */
// far side model: clock sources and rising edge counters on the outputs
`timescale 1ns/100ps
module acs_far_model (
   // clock and control
   input wire logic pclk,
   input wire logic presetn,
   input wire logic count_en,
   input wire logic sr_periodic,
   // sources
   output logic diff_ref_in,
   output logic single_ended_ref_in,
   output logic serdes_clk_in,
   output logic time_mark_in,
   output logic sysref_in,
   // observed outputs and counts
   input wire logic [4:0] outs,
   output logic [4:0][15:0] cnt
);
   logic [15:0] t;
   logic [15:0] w;
   logic [4:0] prev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t <= 16'h0;
         w <= 16'h0;
         prev <= 5'h0;
         cnt <= '0;
      end else begin
         t <= t + 16'h1;
         w <= count_en ? w + 16'h1 : 16'h0;
         prev <= outs;
         for (int i = 0; i < 5; i++) begin
            cnt[i] <= !count_en ? 16'h0 : cnt[i] + {15'h0, outs[i] && !prev[i]};
         end
      end
   end
   // periods 16, 32, 4 and 40 cycles
   assign diff_ref_in = t[3];
   assign single_ended_ref_in = t[4];
   assign serdes_clk_in = t[1];
   assign time_mark_in = (t % 16'd40) < 16'd20;
   // own generator, not the repeat chain; period 64 or one pulse a window
   assign sysref_in = sr_periodic ? t[5:2] == 4'h0 : (w >= 16'd100 && w < 16'd104);
endmodule // acs_far_model

/* tb_top.sv */
// self-checking bench for the clock control block
`timescale 1ns/100ps
module tb_top;
   import acs_pkg::*;
   logic pclk;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic pll_enable_pin = 1'b1;
   logic power_down_pin = 1'b0;
   logic ref_input_select = 1'b0;
   logic [1:0] clock_cfg_pins = 2'h1;
   logic overrange_c_in = 1'b0;
   logic overrange_d_in = 1'b0;
   logic [23:0] taps = 24'h0;
   logic count_en = 1'b0;
   logic sr_periodic = 1'b1;
   logic [31:0] prdata, q;
   logic pready, pslverr, e, diff_ref_in, single_ended_ref_in, serdes_clk_in, time_mark_in;
   logic sysref_in, ref_repeat_out, aux_lvds_out, cmos_out_c, cmos_out_d, sysref_capture;
   logic [4:0][15:0] cnt;
   logic [3:0][3:0] ovt = {4'b1000, 4'b0111, 4'b1110, 4'b1001};
   int errors = 0;
   int checked = 0;
   int cyc = 0;
   acs_clock_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pll_enable_pin, .power_down_pin, .ref_input_select, .clock_cfg_pins,
      .diff_ref_in, .single_ended_ref_in, .serdes_clk_in, .time_mark_in, .sysref_in,
      .sysref_taps_in(taps), .overrange_c_in, .overrange_d_in, .ref_repeat_out,
      .aux_lvds_out, .cmos_out_c, .cmos_out_d, .sysref_capture);
   acs_far_model far (.pclk, .presetn, .count_en, .sr_periodic, .diff_ref_in,
      .single_ended_ref_in, .serdes_clk_in, .time_mark_in, .sysref_in,
      .outs({sysref_capture, cmos_out_d, cmos_out_c, aux_lvds_out, ref_repeat_out}), .cnt);
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("prdata", x, q);
   endtask
   // edge count within one of target, negative means not looked at
   task automatic near(input string n, input int x, input logic [15:0] g);
      checked++;
      if (x >= 0 && (int'(g) < x - 1 || int'(g) > x + 1)) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", n, x, g);
      end
   endtask
   task automatic win(input int r, input int a, input int c, input int d, input int s);
      repeat (40) @(posedge pclk);
      count_en <= 1'b1;
      repeat (641) @(posedge pclk);
      near("repeat edges", r, cnt[0]);
      near("aux edges", a, cnt[1]);
      near("out c edges", c, cnt[2]);
      near("out d edges", d, cnt[3]);
      near("capture pulses", s, cnt[4]);
      count_en <= 1'b0;
   endtask
   function automatic int f(input logic [1:0] s);
      return s == 2'h0 ? 0 : 80 >> s;
   endfunction
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h000, 32'h1);
      rd(12'h004, 32'h0);
      rd(12'h008, 32'h0);
      rd(12'h00c, 32'h0);
      rd(12'h010, 32'h0080_0001);
      apb(1'b1, 12'h020, 32'hffff_ffff);
      rd(12'h020, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      win(40, 0, 40, 40, 10);
      for (int i = 0; i < 4; i++) begin
         clock_cfg_pins <= i[1:0];
         win(40, 0, f(i[1:0]), i == 0 ? 0 : 40, 10);
      end
      ref_input_select <= 1'b1;
      win(20, 0, 5, 20, 10);
      ref_input_select <= 1'b0;
      apb(1'b1, 12'h000, 32'h0);
      win(0, 0, 10, 40, 10);
      apb(1'b1, 12'h000, 32'h1);
      pll_enable_pin <= 1'b0;
      win(0, 0, 10, 40, 10);
      pll_enable_pin <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h008, {27'h0, 1'b1, ovt[i]});
         win(40, 0, f(ovt[i][1:0]), ovt[i][1:0] == 0 ? 0 : f(ovt[i][3:2]), 10);
      end
      rd(12'h008, 32'h18);
      apb(1'b1, 12'h008, 32'h30);
      for (int i = 0; i < 2; i++) begin
         overrange_c_in <= i[0];
         overrange_d_in <= ~i[0];
         repeat (40) @(posedge pclk);
         chk("cmos_out_c", {31'h0, i[0]}, {31'h0, cmos_out_c});
         chk("cmos_out_d", {31'h0, ~i[0]}, {31'h0, cmos_out_d});
      end
      apb(1'b1, 12'h008, 32'h31);
      win(40, 0, 40, 0, 10);
      overrange_c_in <= 1'b0;
      power_down_pin <= 1'b1;
      win(0, 0, 0, 0, 10);
      power_down_pin <= 1'b0;
      apb(1'b1, 12'h004, 32'h7);
      win(40, 16, 40, 0, 10);
      apb(1'b1, 12'h004, 32'h43);
      win(40, 40, 40, 0, 10);
      rd(12'h004, 32'h43);
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h00c, 32'hf);
      rd(12'h00c, 32'hf);
      taps <= 24'h00_0f00;
      repeat (4) @(posedge pclk);
      rd(12'h010, 32'h0080_1101);
      sr_periodic <= 1'b0;
      win(40, 0, 40, 0, 1);
      end_of_test();
   end
endmodule // tb_top
